//--- rtl/prs_regs.svh
`ifndef PRS_REGS_SVH
`define PRS_REGS_SVH
// Summary of operation
// - buck starts on reference ok and primary enable
// - buck regulating enables its detect, charges negative delay
// - negative delay crossing starts ramp; detect after ramp
// - negative ramp 102 steps over 3 ms
// - boost sequence needs buck regulating and secondary enable
// - positive ramp 128 steps, detect suppressed meanwhile
// - positive delay crossing enables positive pump
// - positive regulating charges switch delay, then enables switch
// - boost and positive detect follow their regulation
// - first mode: control high sources, low drains
// - discharge stops at gate threshold, both modes
// - second mode: rising control sources, dumps mode cap
// - second mode: falling control charges cap, then drains
// - switch off, delay node low on disable/fault
// - secondary low or latch stops boost side
// - only primary low, lockout, retry off or latch stops buck side
// - one oscillator, 600 or 450 kHz by strap
// - absent delay capacitors give immediate crossing
// - 50 ms fault retries thrice, then latches

`define PRS_CLK_MHZ 200
`define PRS_SS_TIME_US 3000
`define PRS_NEG_SS_STEPS 102
`define PRS_POS_SS_STEPS 128
`define PRS_FAULT_TIME_MS 50
`define PRS_OFF_TIME_MS 160
`define PRS_RETRY_LIMIT 3
`define PRS_OSC_HI_KHZ 600
`define PRS_OSC_LO_KHZ 450
`define PRS_NEG_STEP_CYC \
  ((`PRS_SS_TIME_US * `PRS_CLK_MHZ) / `PRS_NEG_SS_STEPS)
`define PRS_POS_STEP_CYC \
  ((`PRS_SS_TIME_US * `PRS_CLK_MHZ) / `PRS_POS_SS_STEPS)
`define PRS_FAULT_CYC (`PRS_FAULT_TIME_MS * 1000 * `PRS_CLK_MHZ)
`define PRS_OFF_CYC (`PRS_OFF_TIME_MS * 1000 * `PRS_CLK_MHZ)
`define PRS_OSC_HI_HALF ((`PRS_CLK_MHZ * 1000) / (2 * `PRS_OSC_HI_KHZ))
`define PRS_OSC_LO_HALF ((`PRS_CLK_MHZ * 1000) / (2 * `PRS_OSC_LO_KHZ))
`endif

//--- rtl/prs_pkg.sv
`default_nettype none
package prs_pkg;
  typedef struct packed {
    logic buck_reg;
    logic boost_reg;
    logic pos_reg;
    logic neg_delay_cross;
    logic pos_delay_cross;
    logic sw_delay_cross;
    logic mode_high;
    logic mode_above_quarter;
    logic gate_below_thr;
  } prs_cmp_t;

  typedef struct packed {
    logic buck;
    logic boost;
    logic pos;
    logic neg;
  } prs_fb_low_t;

  typedef struct packed {
    logic buck_en;
    logic buck_fault_det_en;
    logic neg_delay_charge;
    logic neg_pump_en;
    logic neg_fault_det_en;
    logic boost_en;
    logic boost_fault_det_en;
    logic pos_delay_charge;
    logic pos_pump_en;
    logic pos_fault_det_en;
    logic switch_delay_charge;
    logic switch_delay_hold_low;
    logic switch_block_en;
  } prs_rail_t;

  typedef struct packed {
    logic source_switch;
    logic discharge_switch;
    logic mode_cap_discharge;
    logic mode_cap_charge;
  } prs_gate_t;

  typedef enum logic [1:0] {
    PRS_SW_OFF = 2'h0,
    PRS_SW_SOURCE = 2'h1,
    PRS_SW_WAIT = 2'h2,
    PRS_SW_DRAIN = 2'h3
  } prs_sw_state_t;

  typedef enum logic [1:0] {
    PRS_FLT_RUN = 2'h0,
    PRS_FLT_OFF = 2'h1,
    PRS_FLT_LATCH = 2'h2
  } prs_flt_state_t;
endpackage
`default_nettype wire

//--- rtl/prs_panel_rail_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_regs.svh"
module prs_panel_rail_sequencer #(
  parameter int unsigned NEG_STEP_CYCLES = `PRS_NEG_STEP_CYC,
  parameter int unsigned POS_STEP_CYCLES = `PRS_POS_STEP_CYC,
  parameter int unsigned FAULT_CYCLES = `PRS_FAULT_CYC,
  parameter int unsigned OFF_CYCLES = `PRS_OFF_CYC
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic primary_enable,
  input wire logic secondary_enable,
  input wire logic ref_above_lockout,
  input wire logic frequency_select,
  input wire logic gate_control,
  input wire prs_pkg::prs_cmp_t cmp,
  input wire prs_pkg::prs_fb_low_t fb_low,
  output var prs_pkg::prs_rail_t rail,
  output var prs_pkg::prs_gate_t sw_out,
  output logic [7:0] neg_ss_step,
  output logic [7:0] pos_ss_step,
  output logic osc_clk,
  output logic fault_latched,
  output logic retry_off
);
  import prs_pkg::*;

  localparam logic [7:0] NEG_LAST = 8'(`PRS_NEG_SS_STEPS);
  localparam logic [7:0] POS_LAST = 8'(`PRS_POS_SS_STEPS);
  localparam logic [1:0] RETRY_MAX = 2'(`PRS_RETRY_LIMIT);
  localparam logic [7:0] OSC_HI = 8'(`PRS_OSC_HI_HALF);
  localparam logic [7:0] OSC_LO = 8'(`PRS_OSC_LO_HALF);

  prs_flt_state_t flt_state;
  prs_sw_state_t sw_state, next_sw_state;
  logic [24:0] flt_cnt;
  logic [1:0] retries;
  logic en1_q, en2_q, ctl_q, mode2, dis_stop;
  logic strap_taken, frequency_select_hi;
  logic [7:0] osc_cnt, osc_half;
  logic [12:0] ss_cnt [2];
  logic [7:0] ss_step [2];
  logic [1:0] ramp_on;
  logic run1, run2, fault_now, en_toggle, ctl_rise;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // ***********************************************************
  // enable chain
  // ***********************************************************
  assign run1 = ref_above_lockout & primary_enable &
                (flt_state == PRS_FLT_RUN);
  assign run2 = run1 & secondary_enable & rail.buck_fault_det_en;

  // comparator inputs arrive synchronous; all enables are flops
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rail <= '0;
    end else begin
      rail.buck_en <= run1;
      rail.buck_fault_det_en <= run1 &
        (rail.buck_fault_det_en | cmp.buck_reg);
      rail.neg_delay_charge <= run1 &
        (rail.buck_fault_det_en | cmp.buck_reg);
      rail.neg_pump_en <= run1 & (rail.neg_pump_en |
        (rail.neg_delay_charge & cmp.neg_delay_cross));
      rail.neg_fault_det_en <= run1 & rail.neg_pump_en &
        (ss_step[0] == NEG_LAST);
      rail.boost_en <= run2;
      rail.pos_delay_charge <= run2;
      rail.boost_fault_det_en <= run2 &
        (rail.boost_fault_det_en | cmp.boost_reg);
      rail.pos_pump_en <= run2 & (rail.pos_pump_en |
        (rail.pos_delay_charge & cmp.pos_delay_cross));
      rail.pos_fault_det_en <= run2 & rail.pos_pump_en &
        (ss_step[1] == POS_LAST) &
        (rail.pos_fault_det_en | cmp.pos_reg);
      rail.switch_delay_charge <= run2 & rail.pos_pump_en &
        (rail.switch_delay_charge | cmp.pos_reg);
      rail.switch_delay_hold_low <= ~run2;
      rail.switch_block_en <= run2 & (rail.switch_block_en |
        (rail.switch_delay_charge & cmp.sw_delay_cross));
    end
  end

  // ***********************************************************
  // soft-start ramps: index 0 negative pump, 1 positive pump
  // ***********************************************************
  // negative step k means reference 1.25 V minus k/102 of 1 V
  assign ramp_on = {rail.pos_pump_en, rail.neg_pump_en};
  assign neg_ss_step = ss_step[0];
  assign pos_ss_step = ss_step[1];

  for (genvar i = 0; i < 2; i++) begin : g_ramp
    localparam int unsigned STEP_CYC =
      (i == 0) ? NEG_STEP_CYCLES : POS_STEP_CYCLES;
    localparam logic [7:0] LAST = (i == 0) ? NEG_LAST : POS_LAST;
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        ss_cnt[i] <= '0;
        ss_step[i] <= '0;
      end else if (!ramp_on[i]) begin
        ss_cnt[i] <= '0; // restart on every enable
        ss_step[i] <= '0;
      end else if (ss_step[i] != LAST) begin
        if (ss_cnt[i] == 13'(STEP_CYC - 1)) begin
          ss_cnt[i] <= '0;
          ss_step[i] <= ss_step[i] + 8'h01;
        end else begin
          ss_cnt[i] <= ss_cnt[i] + 13'h0001;
        end
      end
    end
  end

  // ***********************************************************
  // fault timer, retry and latch
  // ***********************************************************
  assign fault_now = |({fb_low.buck, fb_low.boost, fb_low.pos,
    fb_low.neg} & {rail.buck_fault_det_en, rail.boost_fault_det_en,
    rail.pos_fault_det_en, rail.neg_fault_det_en});
  assign en_toggle = (primary_enable != en1_q) |
                     (secondary_enable != en2_q);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flt_state <= PRS_FLT_RUN;
      flt_cnt <= '0;
      retries <= '0;
      en1_q <= 1'h0;
      en2_q <= 1'h0;
      fault_latched <= 1'h0;
      retry_off <= 1'h0;
    end else begin
      en1_q <= primary_enable;
      en2_q <= secondary_enable;
      fault_latched <= (flt_state == PRS_FLT_LATCH);
      retry_off <= (flt_state == PRS_FLT_OFF);
      case (flt_state)
        PRS_FLT_RUN: begin
          if (!fault_now) begin
            flt_cnt <= '0;
          end else if (flt_cnt == 25'(FAULT_CYCLES - 1)) begin
            flt_cnt <= '0;
            if (retries == RETRY_MAX) begin
              flt_state <= PRS_FLT_LATCH;
            end else begin
              flt_state <= PRS_FLT_OFF;
              retries <= retries + 2'h1;
            end
          end else begin
            flt_cnt <= flt_cnt + 25'h0000001;
          end
        end
        PRS_FLT_OFF: begin
          if (flt_cnt == 25'(OFF_CYCLES - 1)) begin
            flt_cnt <= '0;
            flt_state <= PRS_FLT_RUN;
          end else begin
            flt_cnt <= flt_cnt + 25'h0000001;
          end
        end
        PRS_FLT_LATCH: begin
          if (en_toggle) begin
            flt_state <= PRS_FLT_RUN;
            retries <= '0;
          end
        end
        default: begin
          flt_state <= PRS_FLT_RUN;
          flt_cnt <= '0;
        end
      endcase
    end
  end

  // ***********************************************************
  // shared oscillator
  // ***********************************************************
  // strap caught on the first edge after reset release
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_taken <= 1'h0;
      frequency_select_hi <= 1'h0;
    end else if (!strap_taken) begin
      strap_taken <= 1'h1;
      frequency_select_hi <= frequency_select;
    end
  end

  assign osc_half = frequency_select_hi ? OSC_HI : OSC_LO;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      osc_cnt <= '0;
      osc_clk <= 1'h0;
    end else if (strap_taken) begin
      if (osc_cnt >= osc_half - 8'h01) begin
        osc_cnt <= '0;
        osc_clk <= ~osc_clk;
      end else begin
        osc_cnt <= osc_cnt + 8'h01;
      end
    end
  end

  // ***********************************************************
  // high-voltage gate switch control
  // ***********************************************************
  assign ctl_rise = gate_control & ~ctl_q;

  always_comb begin
    next_sw_state = sw_state;
    if (!rail.switch_block_en) begin
      next_sw_state = PRS_SW_OFF;
    end else begin
      case (sw_state)
        PRS_SW_OFF: begin
          next_sw_state = gate_control ? PRS_SW_SOURCE : PRS_SW_DRAIN;
        end
        PRS_SW_SOURCE: begin
          if (!gate_control) begin
            next_sw_state = mode2 ? PRS_SW_WAIT : PRS_SW_DRAIN;
          end
        end
        PRS_SW_WAIT: begin
          if (ctl_rise) begin
            next_sw_state = PRS_SW_SOURCE;
          end else if (cmp.mode_above_quarter) begin
            next_sw_state = PRS_SW_DRAIN;
          end
        end
        PRS_SW_DRAIN: begin
          if (mode2 ? ctl_rise : gate_control) begin
            next_sw_state = PRS_SW_SOURCE;
          end
        end
        default: begin
          next_sw_state = PRS_SW_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sw_state <= PRS_SW_OFF;
      ctl_q <= 1'h0;
      mode2 <= 1'h0;
      dis_stop <= 1'h0;
    end else begin
      sw_state <= next_sw_state;
      ctl_q <= gate_control;
      // mode held while enabled so the charging cap cannot flip it
      if (sw_state == PRS_SW_OFF) begin
        mode2 <= ~cmp.mode_high;
      end
      dis_stop <= (next_sw_state == PRS_SW_DRAIN) &
                  (dis_stop | cmp.gate_below_thr);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sw_out <= '0;
    end else begin
      sw_out.source_switch <= (next_sw_state == PRS_SW_SOURCE) |
                              (next_sw_state == PRS_SW_WAIT);
      sw_out.discharge_switch <= (next_sw_state == PRS_SW_DRAIN) &
        ~dis_stop & ~cmp.gate_below_thr;
      sw_out.mode_cap_discharge <= mode2 &
        (next_sw_state == PRS_SW_SOURCE);
      sw_out.mode_cap_charge <= mode2 &
        ((next_sw_state == PRS_SW_WAIT) |
         (next_sw_state == PRS_SW_DRAIN));
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_m2_fall;
    rail.switch_block_en && mode2 && sw_state == PRS_SW_SOURCE &&
      !gate_control;
  endsequence
  sequence s_m2_wait_done;
    rail.switch_block_en && sw_state == PRS_SW_WAIT && !ctl_rise &&
      cmp.mode_above_quarter;
  endsequence

  buck_start_a: assert property (
    (!ref_above_lockout || !primary_enable) |=> !rail.buck_en)
    else $error("buck enabled without reference or primary enable");
  neg_delay_a: assert property (
    $rose(rail.neg_delay_charge) |-> $past(cmp.buck_reg) &&
      rail.buck_fault_det_en)
    else $error("negative delay charged before buck regulation");
  neg_start_a: assert property (
    $rose(rail.neg_pump_en) |->
      $past(rail.neg_delay_charge && cmp.neg_delay_cross))
    else $error("negative pump enabled without delay crossing");
  neg_ramp_a: assert property (
    rail.neg_fault_det_en |-> neg_ss_step == NEG_LAST)
    else $error("negative detect enabled during ramp");
  boost_seq_a: assert property (
    $rose(rail.boost_en) |-> $past(secondary_enable) &&
      $past(rail.buck_fault_det_en))
    else $error("boost started without buck regulation");
  pos_ramp_a: assert property (
    (rail.pos_pump_en && pos_ss_step != POS_LAST) |->
      !rail.pos_fault_det_en)
    else $error("positive detect enabled during ramp");
  pos_start_a: assert property (
    $rose(rail.pos_pump_en) |->
      $past(rail.pos_delay_charge && cmp.pos_delay_cross))
    else $error("positive pump enabled without delay crossing");
  sw_enable_a: assert property (
    $rose(rail.switch_block_en) |->
      $past(rail.switch_delay_charge && cmp.sw_delay_cross))
    else $error("switch block enabled without delay crossing");
  boost_det_a: assert property (
    $rose(rail.boost_fault_det_en) |-> $past(cmp.boost_reg))
    else $error("boost detect enabled before regulation");
  mode1_ctl_a: assert property (
    (rail.switch_block_en && !mode2 && sw_state != PRS_SW_OFF &&
      gate_control) |=> sw_out.source_switch &&
      !sw_out.discharge_switch)
    else $error("first mode control high did not source");
  dis_stop_a: assert property (
    sw_out.discharge_switch |-> !$past(cmp.gate_below_thr))
    else $error("discharge kept on below gate threshold");
  m2_rise_a: assert property (
    (rail.switch_block_en && mode2 && sw_state != PRS_SW_OFF &&
      ctl_rise) |=> sw_out.source_switch && sw_out.mode_cap_discharge)
    else $error("second mode rising edge did not source");
  m2_fall_a: assert property (
    s_m2_fall |=> sw_out.source_switch && sw_out.mode_cap_charge &&
      !sw_out.mode_cap_discharge)
    else $error("second mode fall did not start cap charge");
  m2_drain_a: assert property (
    s_m2_wait_done |=> !sw_out.source_switch && sw_out.mode_cap_charge)
    else $error("second mode did not drain after cap charge");
  hold_low_a: assert property (
    (!primary_enable || !secondary_enable) |=>
      rail.switch_delay_hold_low ##1 !rail.switch_block_en)
    else $error("switch block not disabled on enable low");
  pd_second_a: assert property (
    !secondary_enable |=> !rail.boost_en && !rail.pos_pump_en)
    else $error("boost side on with secondary enable low");
  pd_first_a: assert property (
    (run1 && !secondary_enable) |=> rail.buck_en)
    else $error("buck dropped on secondary enable alone");
  osc_rate_a: assert property (
    $changed(osc_clk) |-> $past(osc_cnt) == osc_half - 8'h01)
    else $error("oscillator half period wrong");
  flt_latch_a: assert property (
    (flt_state == PRS_FLT_RUN && retries == RETRY_MAX && fault_now &&
      flt_cnt == 25'(FAULT_CYCLES - 1)) |-> ##2 fault_latched)
    else $error("fault latch not set after last retry");
endmodule
`default_nettype wire

//--- verification/prs_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module prs_analog_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire prs_pkg::prs_rail_t rail,
  input wire prs_pkg::prs_gate_t sw_out,
  input wire logic mode_pin_high,
  input wire logic [3:0] fb_force,
  input wire logic [7:0] lag,
  output var prs_pkg::prs_cmp_t cmp,
  output var prs_pkg::prs_fb_low_t fb_low
);
  import prs_pkg::*;
  logic [7:0] src;
  logic [7:0] hit;
  logic [7:0] cnt [8];
  logic gate_low;
  logic cap_above;

  // ****************************************
  // comparators trip lag cycles after drive
  // ****************************************
  assign src = {rail.buck_en, rail.neg_delay_charge, rail.boost_en,
    rail.pos_delay_charge, rail.pos_pump_en, rail.switch_delay_charge,
    sw_out.discharge_switch, sw_out.mode_cap_charge};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) cnt[i] <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!src[i]) cnt[i] <= 8'h00;
        else if (cnt[i] != 8'hFF) cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) hit[i] = src[i] && (cnt[i] >= lag);
  end

  // gate stays discharged until sourced; cap stays charged until dumped
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gate_low <= 1'b0;
      cap_above <= 1'b0;
    end else begin
      if (sw_out.source_switch) gate_low <= 1'b0;
      else if (hit[1]) gate_low <= 1'b1;
      if (sw_out.mode_cap_discharge) cap_above <= 1'b0;
      else if (hit[0]) cap_above <= 1'b1;
    end
  end

  always_comb begin
    cmp.buck_reg = hit[7];
    cmp.neg_delay_cross = hit[6];
    cmp.boost_reg = hit[5];
    cmp.pos_delay_cross = hit[4];
    cmp.pos_reg = hit[3];
    cmp.sw_delay_cross = hit[2];
    cmp.mode_high = mode_pin_high;
    cmp.mode_above_quarter = mode_pin_high | cap_above;
    cmp.gate_below_thr = gate_low;
    fb_low = prs_fb_low_t'(fb_force | {~hit[7], ~hit[5], ~hit[3], 1'b0});
  end
endmodule
`default_nettype wire

//--- verification/prs_panel_rail_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module prs_panel_rail_sequencer_tb_top;
  import prs_pkg::*;
  localparam int NS = 4;
  localparam int PS = 4;
  localparam int FC = 50;
  localparam int OC = 80;
  logic ref_clk, rstn, primary_enable, secondary_enable, gate_control;
  logic ref_above_lockout, frequency_select, mode_pin_high;
  logic osc_clk, fault_latched, retry_off;
  logic [3:0] fb_force;
  logic [7:0] lag, neg_ss_step, pos_ss_step;
  logic [18:0] obs;
  prs_cmp_t cmp;
  prs_fb_low_t fb_low;
  prs_rail_t rail;
  prs_gate_t sw_out;
  int err_count, samples_checked, cycles, off_cnt, off_len, retries, k;

  // ****************************************
  // design and far side
  // ****************************************
  prs_panel_rail_sequencer #(.NEG_STEP_CYCLES(NS), .POS_STEP_CYCLES(PS),
    .FAULT_CYCLES(FC), .OFF_CYCLES(OC)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .primary_enable(primary_enable),
    .secondary_enable(secondary_enable),
    .ref_above_lockout(ref_above_lockout),
    .frequency_select(frequency_select), .gate_control(gate_control),
    .cmp(cmp), .fb_low(fb_low), .rail(rail), .sw_out(sw_out),
    .neg_ss_step(neg_ss_step), .pos_ss_step(pos_ss_step),
    .osc_clk(osc_clk), .fault_latched(fault_latched),
    .retry_off(retry_off));
  prs_analog_model model (
    .ref_clk(ref_clk), .rstn(rstn), .rail(rail), .sw_out(sw_out),
    .mode_pin_high(mode_pin_high), .fb_force(fb_force), .lag(lag),
    .cmp(cmp), .fb_low(fb_low));
  assign obs = {rail, sw_out, fault_latched, retry_off};

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      end_sim();
    end
  end

  // counts finished shutdown periods and keeps the last length
  always @(negedge ref_clk) begin
    if (retry_off === 1'b1) begin
      off_cnt++;
    end else if (off_cnt != 0) begin
      off_len = off_cnt;
      off_cnt = 0;
      retries++;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string msg);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t %s: %h vs %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_obs(input int idx, input logic v);
    k = 0;
    while (obs[idx] !== v && k < 3000) begin
      tick(1);
      k++;
    end
  endtask

  task automatic osc_half(output int n);
    logic o;
    o = osc_clk;
    while (osc_clk === o) tick(1);
    o = osc_clk;
    n = 0;
    while (osc_clk === o && n < 999) begin
      tick(1);
      n++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    rstn = 1'b0;
    primary_enable = 1'b0;
    secondary_enable = 1'b0;
    ref_above_lockout = 1'b0;
    frequency_select = 1'b1;
    gate_control = 1'b0;
    mode_pin_high = 1'b1;
    fb_force = 4'h0;
    lag = 8'h00;
    void'($urandom(32'h6BC4));
    tick(6);
    check({rail, sw_out}, 17'h0, "reset outputs");
    tick(6);
    @(posedge ref_clk) rstn <= 1'b1;
    tick(1);
    check(rail.switch_delay_hold_low, 1'b1, "hold low");
    @(posedge ref_clk) primary_enable <= 1'b1;
    tick(4);
    check(rail.buck_en, 1'b0, "lockout");
    @(posedge ref_clk) ref_above_lockout <= 1'b1;
    #1;
    check(rail.buck_en, 1'b0, "buck early");
    tick(1);
    check(rail.buck_en, 1'b1, "buck start");
    tick(1);
    check({rail.buck_fault_det_en, rail.neg_delay_charge, rail.boost_en},
      3'b110, "buck regulating");
    tick(1);
    check({rail.neg_pump_en, rail.neg_fault_det_en, neg_ss_step},
      10'h200, "neg start");
    wait_obs(14, 1'b1);
    check(neg_ss_step, 8'h66, "neg ramp end");
    check(k >= 102 * NS - 2 && k <= 102 * NS + 3, 1'b1, "neg time");
    $display("test done: buck side");

    @(posedge ref_clk) begin
      lag <= 8'h03;
      secondary_enable <= 1'b1;
    end
    tick(1);
    check({rail.boost_en, rail.pos_delay_charge, rail.pos_pump_en},
      3'b110, "boost start");
    wait_obs(10, 1'b1);
    check(k >= 3, 1'b1, "pos delay");
    check({pos_ss_step, rail.pos_fault_det_en}, 9'h0, "pos start");
    wait_obs(9, 1'b1);
    check(pos_ss_step, 8'h80, "pos ramp end");
    check(k >= 128 * PS - 2 && k <= 128 * PS + 6, 1'b1, "pos time");
    check(rail.boost_fault_det_en, 1'b1, "boost detect");
    wait_obs(6, 1'b1);
    check(rail.switch_block_en, 1'b1, "switch on");
    osc_half(k);
    check(k, 166, "osc 600k");
    $display("test done: boost side");

    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk) gate_control <= ~i[0];
      tick(2);
      check({sw_out.source_switch, sw_out.discharge_switch},
        {~i[0], i[0]}, "mode one");
      tick(12 + $urandom % 8);
      check(sw_out.discharge_switch, 1'b0, "drain stop");
    end
    $display("test done: first mode");

    @(posedge ref_clk) begin
      secondary_enable <= 1'b0;
      mode_pin_high <= 1'b0;
    end
    tick(3);
    check({rail.boost_en, rail.pos_pump_en, rail.pos_delay_charge,
      rail.switch_block_en, rail.switch_delay_hold_low},
      5'b00001, "secondary off");
    check({rail.buck_en, rail.neg_pump_en}, 2'b11, "buck kept");
    @(posedge ref_clk) begin
      lag <= 8'h02;
      secondary_enable <= 1'b1;
    end
    wait_obs(6, 1'b1);
    tick(2);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk) gate_control <= 1'b1;
      tick(2);
      check({sw_out.source_switch, sw_out.discharge_switch,
        sw_out.mode_cap_discharge}, 3'b101, "rise");
      tick(3 + $urandom % 8);
      @(posedge ref_clk) gate_control <= 1'b0;
      tick(2);
      check({sw_out.source_switch, sw_out.mode_cap_charge},
        2'b11, "fall");
      wait_obs(5, 1'b0);
      check({k >= 1, sw_out.discharge_switch}, 2'b11, "cap full");
      tick(20);
      check(sw_out.discharge_switch, 1'b0, "drain stop 2");
    end
    $display("test done: second mode");

    @(posedge ref_clk) fb_force <= 4'h8;
    retries = 0;
    wait_obs(1, 1'b1);
    check({retries[3:0], off_len[7:0]}, {4'h3, 8'(OC)}, "retries");
    tick(2);
    check(rail.buck_en, 1'b0, "latched off");
    @(posedge ref_clk) fb_force <= 4'h0;
    tick(10);
    check(fault_latched, 1'b1, "latch holds");
    @(posedge ref_clk) secondary_enable <= 1'b0;
    tick(3);
    check(fault_latched, 1'b0, "latch clear");
    @(posedge ref_clk) secondary_enable <= 1'b1;
    wait_obs(6, 1'b1);
    check(rail.switch_block_en, 1'b1, "restart");
    $display("test done: fault retry");

    @(posedge ref_clk) primary_enable <= 1'b0;
    tick(3);
    check(rail, 13'h0002, "primary off");
    @(posedge ref_clk) begin
      frequency_select <= 1'b0;
      primary_enable <= 1'b1;
      rstn <= 1'b0;
    end
    tick(3);
    @(posedge ref_clk) rstn <= 1'b1;
    osc_half(k);
    check(k, 222, "osc 450k");
    $display("test done: shutdown and strap");
    end_sim();
  end
endmodule
`default_nettype wire
